/* File: rtl/fsac_top.sv */
// Fault status and fault address capture with register port and interrupt.
`timescale 1ns/10ps
module fsac_top
  import fsac_pkg::*;
(
  input  wire logic              sys_clk,      // Core clock, 200 MHz.
  input  wire logic              reset_n,      // Sync reset, active low.
  input  wire logic [ADDR_W-1:0] reg_addr,     // Register byte offset.
  input  wire logic [DATA_W-1:0] reg_wdata,    // Write data.
  input  wire logic              reg_we,       // Write strobe.
  input  wire logic              reg_re,       // Read strobe.
  input  wire logic              reg_priv,     // Access is privileged.
  input  wire fsac_core_evt_t    core_evt,     // Fault events from core.
  output logic [DATA_W-1:0]      reg_rdata_q,  // Read data, next cycle.
  output logic                   reg_err_q,    // Refused access pulse.
  output logic                   hf_take_q,    // Enter hard fault pulse.
  output logic [31:0]            ret_pc_q,     // Return address to stack.
  output logic                   irq_q         // Level interrupt.
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : hit

  function automatic logic is_priv_reg(input logic [ADDR_W-1:0] a);
    is_priv_reg = hit(a, OFS_MEMORY_FAULT_ADDR) ||
                  hit(a, OFS_BUS_ERROR_ADDR);
  endfunction : is_priv_reg

  logic        acc_ok;
  logic        wr;
  logic        wr_hfs;
  logic        wr_mfa;
  logic        wr_bea;
  logic        wr_evs;
  logic        wr_msk;
  logic        wr_val;
  logic        esc_evt;
  logic        forced_q;
  logic        vect_q;
  logic [EV_W-1:0] ev_status_q;
  logic [EV_W-1:0] ev_mask_q;
  logic [EV_W-1:0] ev_set;
  logic [31:0] mem_addr_q;
  logic [31:0] bus_addr_q;
  logic        mem_valid_q;
  logic        bus_valid_q;
  logic [31:0] rd_word;

  // Unprivileged software may not touch the address registers.
  assign acc_ok = reg_priv || !is_priv_reg(reg_addr);
  assign wr     = reg_we && acc_ok;
  assign wr_hfs = wr && hit(reg_addr, OFS_HARD_FAULT_STATUS);
  assign wr_mfa = wr && hit(reg_addr, OFS_MEMORY_FAULT_ADDR);
  assign wr_bea = wr && hit(reg_addr, OFS_BUS_ERROR_ADDR);
  assign wr_evs = wr && hit(reg_addr, OFS_EVENT_STATUS);
  assign wr_msk = wr && hit(reg_addr, OFS_EVENT_MASK);
  assign wr_val = wr && hit(reg_addr, OFS_ADDR_VALID);

  // A configurable fault that cannot be taken escalates.
  assign esc_evt = core_evt.esc_fault && !core_evt.esc_can_take;

  // Set wins over a simultaneous write-one-to-clear.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      forced_q <= 1'b0;
    end else begin
      forced_q <= (forced_q && !(wr_hfs && reg_wdata[BIT_FORCED]))
                  || esc_evt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      vect_q <= 1'b0;
    end else begin
      vect_q <= (vect_q && !(wr_hfs && reg_wdata[BIT_VECTOR]))
                || core_evt.vec_err;
    end
  end

  // Vector fetch errors bypass every configurable handler.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hf_take_q <= 1'b0;
    end else begin
      hf_take_q <= core_evt.vec_err || esc_evt;
    end
  end

  // The failed entry never started its handler, so the preempted
  // instruction is where execution resumes.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ret_pc_q <= RST_WORD;
    end else if (core_evt.vec_err) begin
      ret_pc_q <= core_evt.preempt_pc;
    end
  end

  // The core reports the address of the aligned piece that failed, which
  // lies anywhere in the requested span; it is kept as given.
  fsac_addr_capture u_mem_cap (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .fault      (core_evt.mem_fault),
    .fault_addr (core_evt.mem_addr),
    .sw_we      (wr_mfa),
    .sw_wdata   (reg_wdata),
    .valid_clr  (wr_val && reg_wdata[BIT_MEM_VAL]),
    .addr_q     (mem_addr_q),
    .valid_q    (mem_valid_q)
  );

  // Bus faults keep the instruction's requested address.
  fsac_addr_capture u_bus_cap (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .fault      (core_evt.bus_fault),
    .fault_addr (core_evt.bus_req_addr),
    .sw_we      (wr_bea),
    .sw_wdata   (reg_wdata),
    .valid_clr  (wr_val && reg_wdata[BIT_BUS_VAL]),
    .addr_q     (bus_addr_q),
    .valid_q    (bus_valid_q)
  );

  assign ev_set[EV_FORCED] = esc_evt;
  assign ev_set[EV_VECTOR] = core_evt.vec_err;
  assign ev_set[EV_MEM]    = core_evt.mem_fault;
  assign ev_set[EV_BUS]    = core_evt.bus_fault;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ev_status_q <= RST_EV;
    end else begin
      ev_status_q <= (ev_status_q & ~(wr_evs ? reg_wdata[EV_W-1:0] : RST_EV))
                     | ev_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ev_mask_q <= RST_EV;
    end else if (wr_msk) begin
      ev_mask_q <= reg_wdata[EV_W-1:0];
    end
  end

  // Registered, so the line rises one cycle after the status bit.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev_status_q & ev_mask_q);
    end
  end

  always_comb begin
    rd_word = RST_WORD;
    if (hit(reg_addr, OFS_HARD_FAULT_STATUS)) begin
      rd_word[BIT_FORCED] = forced_q;
      rd_word[BIT_VECTOR] = vect_q;
    end else if (hit(reg_addr, OFS_MEMORY_FAULT_ADDR)) begin
      rd_word = mem_addr_q;
    end else if (hit(reg_addr, OFS_BUS_ERROR_ADDR)) begin
      rd_word = bus_addr_q;
    end else if (hit(reg_addr, OFS_EVENT_STATUS)) begin
      rd_word[EV_W-1:0] = ev_status_q;
    end else if (hit(reg_addr, OFS_EVENT_MASK)) begin
      rd_word[EV_W-1:0] = ev_mask_q;
    end else if (hit(reg_addr, OFS_ADDR_VALID)) begin
      rd_word[BIT_MEM_VAL] = mem_valid_q;
      rd_word[BIT_BUS_VAL] = bus_valid_q;
    end
  end

  // A refused read returns zero so no address leaks to user code.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata_q <= RST_WORD;
    end else if (reg_re && acc_ok) begin
      reg_rdata_q <= rd_word;
    end else begin
      reg_rdata_q <= RST_WORD;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_err_q <= 1'b0;
    end else begin
      reg_err_q <= (reg_re || reg_we) && !acc_ok;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_esc;
    esc_evt;
  endsequence

  sequence s_vec;
    core_evt.vec_err;
  endsequence

  sequence s_hfs_read;
    reg_re && hit(reg_addr, OFS_HARD_FAULT_STATUS);
  endsequence

  sequence s_unpriv_addr_wr;
    reg_we && !reg_priv && is_priv_reg(reg_addr);
  endsequence

  sequence s_unpriv_addr_rd;
    reg_re && !reg_priv && is_priv_reg(reg_addr);
  endsequence

  sequence s_valid_read;
    reg_re && hit(reg_addr, OFS_ADDR_VALID);
  endsequence

  // A flag raised by an event must show in the very next status read.
  sequence s_esc_then_read;
    s_esc ##1 s_hfs_read;
  endsequence

  sequence s_vec_then_read;
    s_vec ##1 s_hfs_read;
  endsequence

  forced_set_a: assert property (
    s_esc |=> forced_q && hf_take_q)
    else $error("Escalated fault did not set forced flag.");

  forced_hold_a: assert property (
    forced_q && !(wr_hfs && reg_wdata[BIT_FORCED]) |=> forced_q)
    else $error("Forced flag dropped without a clear.");

  forced_clear_a: assert property (
    wr_hfs && reg_wdata[BIT_FORCED] && !esc_evt |=> !forced_q)
    else $error("Forced flag ignored write-one-to-clear.");

  vect_set_a: assert property (
    s_vec |=> vect_q ##0 (vect_q || $past(wr_hfs)))
    else $error("Vector fetch error did not set vector flag.");

  vect_route_a: assert property (
    s_vec |=> hf_take_q)
    else $error("Vector fetch error not sent to hard fault.");

  ret_pc_a: assert property (
    s_vec |=> ret_pc_q == $past(core_evt.preempt_pc))
    else $error("Stacked return address is not the preempted one.");

  reserved_zero_a: assert property (
    s_hfs_read and reg_priv |=> reg_rdata_q[29:2] == 28'h0
                               && !reg_rdata_q[0] && !reg_rdata_q[31])
    else $error("Reserved status bits read nonzero.");

  mem_capture_a: assert property (
    core_evt.mem_fault && !mem_valid_q
    |=> mem_addr_q == $past(core_evt.mem_addr) && mem_valid_q)
    else $error("Memory fault address not captured.");

  bus_capture_a: assert property (
    core_evt.bus_fault && !bus_valid_q
    |=> bus_addr_q == $past(core_evt.bus_req_addr) && bus_valid_q)
    else $error("Bus fault requested address not captured.");

  priv_guard_a: assert property (
    s_unpriv_addr_wr and (!core_evt.mem_fault && !core_evt.bus_fault)
    |=> $stable(mem_addr_q) && $stable(bus_addr_q) && reg_err_q)
    else $error("Unprivileged write altered a fault address.");

  irq_level_a: assert property (
    (|(ev_status_q & ev_mask_q)) |=> irq_q)
    else $error("Interrupt missing for unmasked event.");

  irq_quiet_a: assert property (
    !(|(ev_status_q & ev_mask_q)) |=> !irq_q)
    else $error("Interrupt raised with no unmasked event.");

  forced_idle_a: assert property (
    !forced_q && !esc_evt |=> !forced_q)
    else $error("Forced flag set without an escalation.");

  forced_read_a: assert property (
    s_esc_then_read |=> reg_rdata_q[BIT_FORCED])
    else $error("Forced flag missing from the status read.");

  vect_hold_a: assert property (
    vect_q && !(wr_hfs && reg_wdata[BIT_VECTOR]) |=> vect_q)
    else $error("Vector flag dropped without a clear.");

  vect_clear_a: assert property (
    wr_hfs && reg_wdata[BIT_VECTOR] && !core_evt.vec_err |=> !vect_q)
    else $error("Vector flag ignored write-one-to-clear.");

  vect_idle_a: assert property (
    !vect_q && !core_evt.vec_err |=> !vect_q)
    else $error("Vector flag set without a fetch error.");

  vect_read_a: assert property (
    s_vec_then_read |=> reg_rdata_q[BIT_VECTOR])
    else $error("Vector flag missing from the status read.");

  hf_quiet_a: assert property (
    !core_evt.vec_err && !esc_evt |=> !hf_take_q)
    else $error("Hard fault entry without a cause.");

  ret_pc_hold_a: assert property (
    !core_evt.vec_err |=> $stable(ret_pc_q))
    else $error("Stacked return address changed without a vector error.");

  mem_valid_set_a: assert property (
    core_evt.mem_fault |=> mem_valid_q)
    else $error("Memory fault did not mark its address valid.");

  mem_kept_a: assert property (
    mem_valid_q && !wr_mfa |=> $stable(mem_addr_q))
    else $error("Valid memory fault address was overwritten.");

  bus_valid_set_a: assert property (
    core_evt.bus_fault |=> bus_valid_q)
    else $error("Bus fault did not mark its address valid.");

  bus_kept_a: assert property (
    bus_valid_q && !wr_bea |=> $stable(bus_addr_q))
    else $error("Valid bus fault address was overwritten.");

  mem_sw_write_a: assert property (
    wr_mfa && !(core_evt.mem_fault && !mem_valid_q)
    |=> mem_addr_q == $past(reg_wdata))
    else $error("Privileged write to memory fault address lost.");

  bus_sw_write_a: assert property (
    wr_bea && !(core_evt.bus_fault && !bus_valid_q)
    |=> bus_addr_q == $past(reg_wdata))
    else $error("Privileged write to bus fault address lost.");

  priv_read_a: assert property (
    s_unpriv_addr_rd |=> reg_rdata_q == RST_WORD && reg_err_q)
    else $error("Unprivileged read of a fault address not refused.");

  err_quiet_a: assert property (
    acc_ok |=> !reg_err_q)
    else $error("Refusal pulse on an allowed access.");

  valid_read_a: assert property (
    s_valid_read |=> reg_rdata_q ==
                     {30'h0, $past(bus_valid_q), $past(mem_valid_q)})
    else $error("Address valid flags read back wrong.");

endmodule : fsac_top

/* File: rtl/fsac_pkg.sv */
// Shared constants, register map and core event carrier for fault capture.
package fsac_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [11:0] OFS_HARD_FAULT_STATUS = 12'hD2C;
  localparam logic [11:0] OFS_MEMORY_FAULT_ADDR = 12'hD34;
  localparam logic [11:0] OFS_BUS_ERROR_ADDR    = 12'hD38;
  localparam logic [11:0] OFS_EVENT_STATUS      = 12'hD40;
  localparam logic [11:0] OFS_EVENT_MASK        = 12'hD44;
  localparam logic [11:0] OFS_ADDR_VALID        = 12'hD48;

  localparam int BIT_FORCED  = 30;
  localparam int BIT_VECTOR  = 1;
  localparam int BIT_MEM_VAL = 0;
  localparam int BIT_BUS_VAL = 1;

  localparam int EV_FORCED = 0;
  localparam int EV_VECTOR = 1;
  localparam int EV_MEM    = 2;
  localparam int EV_BUS    = 3;
  localparam int EV_W      = 4;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  RST_EV   = 4'h0;

  typedef struct packed {
    logic        esc_fault;
    logic        esc_can_take;
    logic        vec_err;
    logic        mem_fault;
    logic [31:0] mem_addr;
    logic        bus_fault;
    logic [31:0] bus_req_addr;
    logic [31:0] preempt_pc;
  } fsac_core_evt_t;

endpackage : fsac_pkg

/* File: rtl/fsac_addr_capture.sv */
// One fault address register with its address-valid flag.
`timescale 1ns/10ps
module fsac_addr_capture
  import fsac_pkg::*;
(
  input  wire logic        sys_clk,   // Core clock.
  input  wire logic        reset_n,   // Synchronous reset, active low.
  input  wire logic        fault,     // Fault event pulse.
  input  wire logic [31:0] fault_addr,// Address chosen by the caller.
  input  wire logic        sw_we,     // Privileged write to the address.
  input  wire logic [31:0] sw_wdata,  // Write data.
  input  wire logic        valid_clr, // Write-one-to-clear of valid flag.
  output logic      [31:0] addr_q,    // Captured address.
  output logic             valid_q    // Address holds a fault address.
);

  // The first fault is kept until software clears the flag or writes the address,
  // so a burst of follow-on faults cannot hide the original cause.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      addr_q <= RST_WORD;
    end else if (fault && !valid_q) begin
      addr_q <= fault_addr;
    end else if (sw_we) begin
      addr_q <= sw_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= (valid_q && !valid_clr) || fault;
    end
  end

endmodule : fsac_addr_capture

/* File: tb/fsac_core_model.sv */
// Behavioural core model that presents fault events to the capture block.
`timescale 1ns/10ps
module fsac_core_model
  import fsac_pkg::*;
(
  input  wire logic     sys_clk,  // Core clock.
  output fsac_core_evt_t core_evt  // Fault events towards the block.
);
  initial core_evt = '0;

  // Addresses are inverted between events so stale values never match.
  task automatic send(input fsac_core_evt_t e);
    fsac_core_evt_t idle;
    idle              = '0;
    idle.mem_addr     = ~e.mem_addr;
    idle.bus_req_addr = ~e.bus_req_addr;
    idle.preempt_pc   = ~e.preempt_pc;
    @(posedge sys_clk) core_evt <= e;
    @(posedge sys_clk) core_evt <= idle;
  endtask : send
endmodule : fsac_core_model

/* File: tb/fsac_top_test.sv */
// Self-checking testbench for fault status and fault address capture.
`timescale 1ns/10ps
module fsac_top_test
  import fsac_pkg::*;
;
  logic              sys_clk;
  logic              reset_n;
  logic              reg_we;
  logic              reg_re;
  logic              reg_priv;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata_q;
  logic              reg_err_q;
  logic              hf_take_q;
  logic              irq_q;
  logic [31:0]       ret_pc_q;
  fsac_core_evt_t    core_evt;
  fsac_core_evt_t    e;
  int                fail_count;
  int                check_count;

  fsac_top fsac_top_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_priv(reg_priv), .core_evt(core_evt),
    .reg_rdata_q(reg_rdata_q), .reg_err_q(reg_err_q),
    .hf_take_q(hf_take_q), .ret_pc_q(ret_pc_q), .irq_q(irq_q));

  fsac_core_model fsac_core_model_i (.sys_clk(sys_clk), .core_evt(core_evt));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic p, input logic [31:0] d);
    @(posedge sys_clk) begin
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_priv  <= p;
      reg_wdata <= d;
    end
    @(posedge sys_clk) reg_we <= 1'b0;
    #1;
  endtask : wr

  // Read data and the refusal pulse stand only in the cycle after the strobe.
  task automatic rd(input logic [11:0] a, input logic p, input logic [31:0] x,
                    input logic er);
    @(posedge sys_clk) begin
      reg_re   <= 1'b1;
      reg_addr <= a;
      reg_priv <= p;
    end
    @(posedge sys_clk) reg_re <= 1'b0;
    #1;
    chk($sformatf("rdata %h", a), reg_rdata_q, x);
    chk("reg_err_q", {31'h0, reg_err_q}, {31'h0, er});
  endtask : rd

  task automatic finish_test;
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    fail_count = 0;
    check_count = 0;
    reset_n = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_priv = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(OFS_HARD_FAULT_STATUS, 1'b1, 32'h0, 1'b0);
    rd(OFS_ADDR_VALID, 1'b1, 32'h0, 1'b0);
    wr(OFS_MEMORY_FAULT_ADDR, 1'b1, 32'hA5A5_5A5A);
    rd(OFS_MEMORY_FAULT_ADDR, 1'b1, 32'hA5A5_5A5A, 1'b0);
    wr(OFS_BUS_ERROR_ADDR, 1'b1, 32'h5A5A_A5A5);
    rd(OFS_BUS_ERROR_ADDR, 1'b1, 32'h5A5A_A5A5, 1'b0);
    wr(OFS_MEMORY_FAULT_ADDR, 1'b0, 32'h1234_5678);
    chk("write refused", {31'h0, reg_err_q}, 32'h1);
    rd(OFS_MEMORY_FAULT_ADDR, 1'b0, 32'h0, 1'b1);
    rd(OFS_BUS_ERROR_ADDR, 1'b0, 32'h0, 1'b1);
    rd(OFS_MEMORY_FAULT_ADDR, 1'b1, 32'hA5A5_5A5A, 1'b0);
    rd(12'hD50, 1'b1, 32'h0, 1'b0);
    wr(OFS_EVENT_MASK, 1'b1, 32'h0000_000F);
    // A fault that the core can still take must not escalate.
    e = '0;
    e.esc_fault = 1'b1;
    e.esc_can_take = 1'b1;
    fsac_core_model_i.send(e);
    #1;
    chk("hf_take_q", {31'h0, hf_take_q}, 32'h0);
    rd(OFS_HARD_FAULT_STATUS, 1'b1, 32'h0, 1'b0);
    e.esc_can_take = 1'b0;
    fsac_core_model_i.send(e);
    #1;
    chk("hf_take_q", {31'h0, hf_take_q}, 32'h1);
    rd(OFS_HARD_FAULT_STATUS, 1'b1, 32'h4000_0000, 1'b0);
    chk("irq_q", {31'h0, irq_q}, 32'h1);
    e = '0;
    e.vec_err = 1'b1;
    e.preempt_pc = 32'h0000_1F3E;
    fsac_core_model_i.send(e);
    #1;
    chk("hf_take_q", {31'h0, hf_take_q}, 32'h1);
    chk("ret_pc_q", ret_pc_q, 32'h0000_1F3E);
    rd(OFS_HARD_FAULT_STATUS, 1'b1, 32'h4000_0002, 1'b0);
    wr(OFS_HARD_FAULT_STATUS, 1'b1, 32'h4000_0000);
    rd(OFS_HARD_FAULT_STATUS, 1'b1, 32'h0000_0002, 1'b0);
    wr(OFS_HARD_FAULT_STATUS, 1'b1, 32'h0000_0002);
    rd(OFS_HARD_FAULT_STATUS, 1'b1, 32'h0, 1'b0);
    rd(OFS_EVENT_STATUS, 1'b1, 32'h0000_0003, 1'b0);
    wr(OFS_EVENT_STATUS, 1'b1, 32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq_q", {31'h0, irq_q}, 32'h0);
    // The actual piece address of an unaligned access is presented.
    e = '0;
    e.mem_fault = 1'b1;
    e.mem_addr = 32'h2000_0103;
    fsac_core_model_i.send(e);
    rd(OFS_ADDR_VALID, 1'b1, 32'h0000_0001, 1'b0);
    rd(OFS_MEMORY_FAULT_ADDR, 1'b1, 32'h2000_0103, 1'b0);
    e.mem_addr = 32'h2000_0200;
    fsac_core_model_i.send(e);
    rd(OFS_MEMORY_FAULT_ADDR, 1'b1, 32'h2000_0103, 1'b0);
    wr(OFS_ADDR_VALID, 1'b1, 32'h0000_0001);
    rd(OFS_ADDR_VALID, 1'b1, 32'h0, 1'b0);
    e = '0;
    e.bus_fault = 1'b1;
    e.bus_req_addr = 32'h2000_0101;
    fsac_core_model_i.send(e);
    rd(OFS_ADDR_VALID, 1'b1, 32'h0000_0002, 1'b0);
    rd(OFS_BUS_ERROR_ADDR, 1'b1, 32'h2000_0101, 1'b0);
    chk("irq_q", {31'h0, irq_q}, 32'h1);
    wr(OFS_EVENT_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq_q", {31'h0, irq_q}, 32'h0);
    rd(OFS_EVENT_STATUS, 1'b1, 32'h0000_000C, 1'b0);
    finish_test();
  end
endmodule : fsac_top_test
